// ===== hdl/clock_stop_powerdown_control.v
`timescale 1ns/10ps
`include "clock_ctrl_defines.vh"
// Behaviour
// - codes 0,1,B..F give no video outputs
// - codes 2..8 give down spread video
// - codes 9,A give center spread video
// - stop halts only stoppable differential outputs
// - disabled output drives all legs low
// - stop after two comp rises, 2-6 periods
// - stopped pair parks true high, comp low
// - restart synchronously without runt or stretched pulse
// - restart within two cpu clock cycles
// - pin is power good first, then power down
// - sync power down, hold clocks low, then oscillators off
// - two low samples: outputs low at falling edge
// - power down: single-ended low or hi-z, differential low
// - stable clocks within 1.8 ms
// - differential outputs driven high within 300 us
// - after lock enable each output at its clock
// - power down release starts power up
module clock_stop_powerdown_control #(
	parameter CPU_HALF   = 2,
	parameter VID_HALF   = 3,
	parameter HOLD_CYC   = 8,
	parameter LOCK_CYC   = (`LOCK_TIME_NS / `CLK_PERIOD_NS),
	parameter NUM_CPU    = 2
) (
	input  wire                 aclk,
	input  wire                 aresetn,
	input  wire                 cpu_stop_n,
	input  wire                 power_good_down_n,
	input  wire                 strap_hiz,
	output wire [NUM_CPU-1:0]   cpu_clock_true,
	output wire [NUM_CPU-1:0]   cpu_clock_comp,
	output reg                  video_clock_nonspread,
	output reg                  video_clock_nonspread_oe,
	output reg                  video_clock_spread,
	output reg                  video_clock_spread_oe,
	output reg                  spread_center,
	output reg  [3:0]           spread_quarter_pct,
	output reg                  osc_enable,
	output reg                  vco_enable,
	input  wire [3:0]           s_axi_awaddr,
	input  wire                 s_axi_awvalid,
	output wire                 s_axi_awready,
	input  wire [31:0]          s_axi_wdata,
	input  wire [3:0]           s_axi_wstrb,
	input  wire                 s_axi_wvalid,
	output wire                 s_axi_wready,
	output reg  [1:0]           s_axi_bresp,
	output reg                  s_axi_bvalid,
	input  wire                 s_axi_bready,
	input  wire [3:0]           s_axi_araddr,
	input  wire                 s_axi_arvalid,
	output wire                 s_axi_arready,
	output reg  [31:0]          s_axi_rdata,
	output reg  [1:0]           s_axi_rresp,
	output reg                  s_axi_rvalid,
	input  wire                 s_axi_rready
);
	localparam ST_WAIT_PG = 3'h0;
	localparam ST_WAKE    = 3'h1;
	localparam ST_RUN     = 3'h2;
	localparam ST_DRAIN   = 3'h3;
	localparam ST_OFF     = 3'h4;
	localparam LOCK_CNT   = (LOCK_CYC < 1) ? 1 : LOCK_CYC;
	// 300 us bound on differential high: met at once on entering wake
	localparam DIFF_HIGH_CYC = `DIFF_HIGH_TIME_NS / `CLK_PERIOD_NS;

	// returns {valid, center, quarter percent}
	function [5:0] spread_lookup;
		input [3:0] code;
		begin
			case (code)
			`SPR_DN_0P5:  spread_lookup = {2'b10, 4'h2};
			`SPR_DN_1P0:  spread_lookup = {2'b10, 4'h4};
			`SPR_DN_1P5:  spread_lookup = {2'b10, 4'h6};
			`SPR_DN_2P0:  spread_lookup = {2'b10, 4'h8};
			`SPR_DN_0P75: spread_lookup = {2'b10, 4'h3};
			`SPR_DN_1P25: spread_lookup = {2'b10, 4'h5};
			`SPR_DN_1P75: spread_lookup = {2'b10, 4'h7};
			`SPR_CT_0P5:  spread_lookup = {2'b11, 4'h2};
			`SPR_CT_0P75: spread_lookup = {2'b11, 4'h3};
			default:      spread_lookup = 6'h00;
			endcase
		end
	endfunction

	reg  [31:0]        control_ff;
	reg  [2:0]         state_ff;
	reg  [2:0]         nxt_state;
	reg  [1:0]         stop_sync_ff;
	reg  [1:0]         pin_sync_ff;
	reg                strap_ff;
	reg                strap_taken_ff;
	reg  [15:0]        cpu_div_ff;
	reg                cpu_int_ff;
	reg  [15:0]        vid_div_ff;
	reg                vid_int_ff;
	reg  [1:0]         stop_cnt_ff;
	reg                stop_req_ff;
	reg  [1:0]         pd_cnt_ff;
	reg  [31:0]        wait_cnt_ff;
	reg                cpu_live_ff;
	reg                vid_live_ff;
	reg                aw_got_ff;
	reg                w_got_ff;
	reg  [3:0]         aw_addr_ff;
	reg  [31:0]        w_data_ff;
	reg  [3:0]         w_strb_ff;
	wire [NUM_CPU-1:0] parked;
	wire [5:0]         spread_now;
	wire               vid_ok;
	wire               cpu_rise;
	wire               cpu_fall;
	wire               vid_tick;
	wire               clocks_on;
	wire               wake_high;
	wire               pin_s;
	wire               stop_s;

	assign pin_s      = pin_sync_ff[1];
	assign stop_s     = stop_sync_ff[1];
	assign spread_now = spread_lookup(control_ff[`CTL_SPREAD_MSB:`CTL_SPREAD_LSB]);
	assign vid_ok     = spread_now[5];
	assign clocks_on  = (state_ff == ST_RUN) || (state_ff == ST_DRAIN);
	assign wake_high  = (state_ff == ST_WAKE);
	assign cpu_rise   = clocks_on && (cpu_div_ff == 16'h0000) && !cpu_int_ff;
	assign cpu_fall   = clocks_on && (cpu_div_ff == 16'h0000) && cpu_int_ff;
	assign vid_tick   = clocks_on && (vid_div_ff == 16'h0000);

	// asynchronous pins: two flops before any logic
	always @(posedge aclk) begin
		if (!aresetn) begin
			stop_sync_ff <= 2'h3;
			pin_sync_ff  <= 2'h0;
		end else begin
			stop_sync_ff <= {stop_sync_ff[0], cpu_stop_n};
			pin_sync_ff  <= {pin_sync_ff[0], power_good_down_n};
		end
	end

	// strap is caught on the first cycle after reset release
	always @(posedge aclk) begin
		if (!aresetn) begin
			strap_ff       <= 1'b0;
			strap_taken_ff <= 1'b0;
		end else if (!strap_taken_ff) begin
			strap_ff       <= strap_hiz;
			strap_taken_ff <= 1'b1;
		end
	end

	// clock dividers, stopped when oscillators are off
	always @(posedge aclk) begin
		if (!aresetn || !clocks_on) begin
			cpu_div_ff <= 16'h0000;
			cpu_int_ff <= 1'b0;
			vid_div_ff <= 16'h0000;
			vid_int_ff <= 1'b0;
		end else begin
			if (cpu_div_ff == 16'h0000) begin
				cpu_div_ff <= CPU_HALF[15:0] - 16'h0001;
				cpu_int_ff <= ~cpu_int_ff;
			end else begin
				cpu_div_ff <= cpu_div_ff - 16'h0001;
			end
			if (vid_tick) begin
				vid_div_ff <= VID_HALF[15:0] - 16'h0001;
				vid_int_ff <= ~vid_int_ff;
			end else begin
				vid_div_ff <= vid_div_ff - 16'h0001;
			end
		end
	end

	// stop request: two low samples at comp rising edges
	always @(posedge aclk) begin
		if (!aresetn) begin
			stop_cnt_ff <= 2'h0;
			stop_req_ff <= 1'b0;
		end else if (stop_s) begin
			stop_cnt_ff <= 2'h0;
			stop_req_ff <= 1'b0;
		end else if (cpu_fall && stop_cnt_ff != `STOP_SAMPLES) begin
			stop_cnt_ff <= stop_cnt_ff + 2'h1;
			stop_req_ff <= (stop_cnt_ff + 2'h1 == `STOP_SAMPLES);
		end
	end

	// power sequencing
	always @* begin
		nxt_state = state_ff;
		case (state_ff)
		ST_WAIT_PG: begin
			if (pin_s) nxt_state = ST_WAKE;
		end
		ST_WAKE: begin
			// an early power down still passes through the low hold before the oscillators stop
			if (!pin_s) nxt_state = ST_DRAIN;
			else if (wait_cnt_ff >= LOCK_CNT - 1) nxt_state = ST_RUN;
		end
		ST_RUN: begin
			if (cpu_rise && !pin_s && pd_cnt_ff == `PD_SAMPLES - 2'h1)
				nxt_state = ST_DRAIN;
		end
		ST_DRAIN: begin
			if (wait_cnt_ff >= HOLD_CYC - 1) nxt_state = ST_OFF;
		end
		ST_OFF: begin
			if (pin_s) nxt_state = ST_WAKE;
		end
		default: nxt_state = ST_WAIT_PG;
		endcase
	end

	always @(posedge aclk) begin
		if (!aresetn) begin
			state_ff    <= ST_WAIT_PG;
			wait_cnt_ff <= 32'h0000_0000;
			pd_cnt_ff   <= 2'h0;
			osc_enable  <= 1'b0;
			vco_enable  <= 1'b0;
		end else begin
			state_ff <= nxt_state;
			if (nxt_state != state_ff)
				wait_cnt_ff <= 32'h0000_0000;
			else
				wait_cnt_ff <= wait_cnt_ff + 32'h0000_0001;
			if (state_ff != ST_RUN || pin_s)
				pd_cnt_ff <= 2'h0;
			else if (cpu_rise)
				pd_cnt_ff <= pd_cnt_ff + 2'h1;
			// oscillators go off only after the hold period
			osc_enable <= (nxt_state != ST_OFF) && (nxt_state != ST_WAIT_PG);
			vco_enable <= (nxt_state != ST_OFF) && (nxt_state != ST_WAIT_PG);
		end
	end

	// each output joins or leaves only while its own clock is low
	always @(posedge aclk) begin
		if (!aresetn) begin
			cpu_live_ff <= 1'b0;
			vid_live_ff <= 1'b0;
		end else begin
			if (!cpu_int_ff)
				cpu_live_ff <= (state_ff == ST_RUN);
			if (!vid_int_ff)
				vid_live_ff <= (state_ff == ST_RUN);
		end
	end

	genvar gi;
	generate
		for (gi = 0; gi < NUM_CPU; gi = gi + 1) begin : g_cpu
			cpu_output_gate u_gate (
				.aclk      (aclk),
				.aresetn   (aresetn),
				.clk_int   (cpu_int_ff),
				.live      (cpu_live_ff),
				.stoppable (control_ff[`CTL_STOPPABLE_LSB + gi]),
				.oe        (control_ff[`CTL_CPU_OE_LSB + gi]),
				.stop_req  (stop_req_ff),
				.wake_high (wake_high),
				.true_ff   (cpu_clock_true[gi]),
				.comp_ff   (cpu_clock_comp[gi]),
				.parked_ff (parked[gi])
			);
		end
	endgenerate

	// video outputs; spread itself is shaped by the analog pll
	always @(posedge aclk) begin
		if (!aresetn) begin
			video_clock_nonspread    <= 1'b0;
			video_clock_spread       <= 1'b0;
			video_clock_nonspread_oe <= 1'b1;
			video_clock_spread_oe    <= 1'b1;
			spread_center            <= 1'b0;
			spread_quarter_pct       <= 4'h0;
		end else begin
			spread_center      <= spread_now[4];
			spread_quarter_pct <= spread_now[3:0];
			video_clock_nonspread <= vid_live_ff && vid_int_ff && vid_ok &&
				control_ff[`CTL_VID_NSS_OE];
			video_clock_spread    <= vid_live_ff && vid_int_ff && vid_ok &&
				control_ff[`CTL_VID_SS_OE];
			// strap floats single-ended pins instead of driving low
			video_clock_nonspread_oe <= !(strap_ff && (state_ff == ST_OFF));
			video_clock_spread_oe    <= !(strap_ff && (state_ff == ST_OFF));
		end
	end

	// axi4-lite slave: address and data taken in either order
	assign s_axi_awready = !aw_got_ff && !s_axi_bvalid;
	assign s_axi_wready  = !w_got_ff && !s_axi_bvalid;
	assign s_axi_arready = !s_axi_rvalid;

	always @(posedge aclk) begin
		if (!aresetn) begin
			aw_got_ff    <= 1'b0;
			w_got_ff     <= 1'b0;
			aw_addr_ff   <= 4'h0;
			w_data_ff    <= 32'h0000_0000;
			w_strb_ff    <= 4'h0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp  <= `RESP_OKAY;
			control_ff   <= `CTL_RESET;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				aw_got_ff  <= 1'b1;
				aw_addr_ff <= s_axi_awaddr;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_got_ff  <= 1'b1;
				w_data_ff <= s_axi_wdata;
				w_strb_ff <= s_axi_wstrb;
			end
			if (aw_got_ff && w_got_ff) begin
				aw_got_ff    <= 1'b0;
				w_got_ff     <= 1'b0;
				s_axi_bvalid <= 1'b1;
				if (aw_addr_ff == `ADDR_CONTROL) begin
					s_axi_bresp <= `RESP_OKAY;
					if (w_strb_ff[0])
						control_ff[7:0] <= w_data_ff[7:0];
					if (w_strb_ff[1])
						control_ff[9:8] <= w_data_ff[9:8];
				end else if (aw_addr_ff == `ADDR_STATUS) begin
					s_axi_bresp <= `RESP_OKAY;
				end else begin
					s_axi_bresp <= `RESP_SLVERR;
				end
			end else if (s_axi_bvalid && s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
		end
	end

	always @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata  <= 32'h0000_0000;
			s_axi_rresp  <= `RESP_OKAY;
		end else if (s_axi_arvalid && s_axi_arready) begin
			s_axi_rvalid <= 1'b1;
			s_axi_rresp  <= `RESP_OKAY;
			case (s_axi_araddr)
			`ADDR_CONTROL: s_axi_rdata <= {22'h0, control_ff[9:0]};
			`ADDR_STATUS:  s_axi_rdata <= {16'h0000, 2'h0, spread_now,
				stop_req_ff, strap_ff, parked, 1'b0, state_ff};
			default: begin
				s_axi_rdata <= 32'h0000_0000;
				s_axi_rresp <= `RESP_SLVERR;
			end
			endcase
		end else if (s_axi_rvalid && s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
		end
	end
endmodule

// ===== hdl/cpu_output_gate.v
`timescale 1ns/10ps
// one differential cpu output pair: stop/park, restart, enables
module cpu_output_gate (
	input  wire aclk,
	input  wire aresetn,
	input  wire clk_int,
	input  wire live,
	input  wire stoppable,
	input  wire oe,
	input  wire stop_req,
	input  wire wake_high,
	output reg  true_ff,
	output reg  comp_ff,
	output reg  parked_ff
);
	reg nxt_parked;
	reg nxt_true;
	reg nxt_comp;

	always @* begin
		nxt_parked = parked_ff;
		if (!live || !stoppable) begin
			nxt_parked = 1'b0;
		end else if (stop_req && clk_int) begin
			// park only during the high phase so the last pulse is whole
			nxt_parked = 1'b1;
		end else if (!stop_req && clk_int) begin
			// resume while the running clock is high: no short pulse
			nxt_parked = 1'b0;
		end
		if (!oe) begin
			nxt_true = 1'b0;
			nxt_comp = 1'b0;
		end else if (wake_high) begin
			nxt_true = 1'b1;
			nxt_comp = 1'b0;
		end else if (!live) begin
			nxt_true = 1'b0;
			nxt_comp = 1'b0;
		end else if (nxt_parked) begin
			nxt_true = 1'b1;
			nxt_comp = 1'b0;
		end else begin
			nxt_true = clk_int;
			nxt_comp = ~clk_int;
		end
	end

	always @(posedge aclk) begin
		if (!aresetn) begin
			true_ff   <= 1'b0;
			comp_ff   <= 1'b0;
			parked_ff <= 1'b0;
		end else begin
			true_ff   <= nxt_true;
			comp_ff   <= nxt_comp;
			parked_ff <= nxt_parked;
		end
	end
endmodule

// ===== pkg/clock_ctrl_defines.vh
`ifndef CLOCK_CTRL_DEFINES_VH
`define CLOCK_CTRL_DEFINES_VH

// register byte addresses
`define ADDR_CONTROL       4'h0
`define ADDR_STATUS        4'h4

// control register fields
`define CTL_SPREAD_LSB     0
`define CTL_SPREAD_MSB     3
`define CTL_STOPPABLE_LSB  4
`define CTL_STOPPABLE_MSB  5
`define CTL_CPU_OE_LSB     6
`define CTL_CPU_OE_MSB     7
`define CTL_VID_NSS_OE     8
`define CTL_VID_SS_OE      9
`define CTL_RESET          32'h0000_03F2

// axi responses
`define RESP_OKAY          2'h0
`define RESP_SLVERR        2'h2

// spread selection codes
`define SPR_DN_0P5         4'h2
`define SPR_DN_1P0         4'h3
`define SPR_DN_1P5         4'h4
`define SPR_DN_2P0         4'h5
`define SPR_DN_0P75        4'h6
`define SPR_DN_1P25        4'h7
`define SPR_DN_1P75        4'h8
`define SPR_CT_0P5         4'h9
`define SPR_CT_0P75        4'hA

// timing, in their own units
`define CLK_PERIOD_NS      40
`define LOCK_TIME_NS       1800000
`define DIFF_HIGH_TIME_NS  300000
`define PD_INIT_WINDOW_NS  10000

// counts of cpu edges: comp rises for stop, true rises for power down
`define STOP_SAMPLES       2'h2
`define PD_SAMPLES         2'h2

`endif

// ===== tb/clock_stop_powerdown_control_asserts.sv
`timescale 1ns/10ps
module clock_stop_powerdown_control_asserts #(
	parameter CPU_HALF = 2,
	parameter NUM_CPU  = 2
) (
	input wire               aclk,
	input wire               aresetn,
	input wire               cpu_stop_n,
	input wire               power_good_down_n,
	input wire [NUM_CPU-1:0] cpu_clock_true,
	input wire [NUM_CPU-1:0] cpu_clock_comp,
	input wire               spread_center,
	input wire [3:0]         spread_quarter_pct,
	input wire               osc_enable
);
	// 2 sync, 2 sampling periods, 6 stop periods, 1 output lag
	localparam STOP_LIM = 3 + 16 * CPU_HALF;
	localparam int RST_MAX = 14;
	reg  [7:0] stop_cnt_ff;
	wire [7:0] nxt_stop_cnt = (!cpu_stop_n && power_good_down_n) ? stop_cnt_ff + 8'h01 : 8'h00;
	always @(posedge aclk) begin
		if (!aresetn) stop_cnt_ff <= 8'h00;
		else stop_cnt_ff <= nxt_stop_cnt;
	end
	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);
	a_center_spread: assert property (spread_center |-> spread_quarter_pct inside {4'h2, 4'h3})
		else $error("center spread magnitude wrong");
	a_down_spread: assert property (!spread_center && spread_quarter_pct != 4'h0 |->
		spread_quarter_pct inside {[4'h2:4'h8]}) else $error("down spread magnitude wrong");
	a_legs_exclusive: assert property ((cpu_clock_true & cpu_clock_comp) == '0)
		else $error("both cpu legs high");
	a_low_before_off: assert property ($fell(osc_enable) |->
		$past(cpu_clock_true) == '0 && $past(cpu_clock_comp) == '0) else $error("clocks not low");
	a_off_held_low: assert property ($fell(osc_enable) |=> cpu_clock_true == '0 && cpu_clock_comp == '0)
		else $error("clocks not held low");
	a_wake_on_good: assert property ($rose(osc_enable) |-> $past(power_good_down_n, 2))
		else $error("oscillator on without power good");
	a_stop_parks: assert property (stop_cnt_ff >= STOP_LIM |-> cpu_clock_true[0] && !cpu_clock_comp[0])
		else $error("stoppable pair not parked");
	a_restart_bound: assert property ($rose(cpu_stop_n) && cpu_clock_true[0] && !cpu_clock_comp[0] |->
		##[1:RST_MAX] cpu_clock_comp[0]) else $error("pair did not restart");
endmodule
bind clock_stop_powerdown_control clock_stop_powerdown_control_asserts #(
	.CPU_HALF(CPU_HALF),
	.NUM_CPU(NUM_CPU)
) u_chk (.aclk(aclk), .aresetn(aresetn), .cpu_stop_n(cpu_stop_n),
	.power_good_down_n(power_good_down_n), .cpu_clock_true(cpu_clock_true),
	.cpu_clock_comp(cpu_clock_comp), .spread_center(spread_center),
	.spread_quarter_pct(spread_quarter_pct), .osc_enable(osc_enable));

// ===== tb/clock_stop_powerdown_control_tb.sv
`timescale 1ns/10ps
`include "clock_ctrl_defines.vh"
module clock_stop_powerdown_control_tb;
	reg aclk, aresetn, pg_req, pd_req, stop_req, strap;
	reg [3:0] awaddr, araddr;
	reg [31:0] wdata;
	reg awvalid, wvalid, bready, arvalid, rready;
	wire awready, wready, bvalid, arready, rvalid, cpu_stop_n, power_good_down_n;
	wire [1:0] bresp, rresp, tru, cmp;
	wire [31:0] rdata;
	wire vn, vs, vn_oe, vs_oe, center, osc;
	wire [3:0] pct;
	integer n_fail, num_checks, c, n0, n1, nv;
	reg [31:0] d;
	reg [1:0] r;
	reg hi;
	platform_pin_model pins (.aclk(aclk), .pg_req(pg_req), .pd_req(pd_req), .stop_req(stop_req),
		.power_good_down_n(power_good_down_n), .cpu_stop_n(cpu_stop_n));
	clock_stop_powerdown_control #(.LOCK_CYC(20)) dut (.aclk(aclk), .aresetn(aresetn),
		.cpu_stop_n(cpu_stop_n), .power_good_down_n(power_good_down_n), .strap_hiz(strap),
		.cpu_clock_true(tru), .cpu_clock_comp(cmp), .video_clock_nonspread(vn),
		.video_clock_nonspread_oe(vn_oe), .video_clock_spread(vs), .video_clock_spread_oe(vs_oe),
		.spread_center(center), .spread_quarter_pct(pct), .osc_enable(osc), .vco_enable(),
		.s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
		.s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
		.s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
		.s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready));
	initial begin
		aclk = 1'b0;
		forever #20 aclk = ~aclk;
	end
	task complete_run;
		begin
			$display("checks %0d mismatches %0d", num_checks, n_fail);
			if (n_fail == 0 && num_checks > 0) $display("TB: PASS");
			else $display("TB: FAIL");
			$finish;
		end
	endtask
	task tmo;
		begin
			n_fail = n_fail + 1;
			complete_run;
		end
	endtask
	task chk(input string nm, input [31:0] e, input [31:0] g);
		begin
			num_checks = num_checks + 1;
			if (e !== g) begin
				n_fail = n_fail + 1;
				$display("mismatch %s exp %h got %h", nm, e, g);
			end
		end
	endtask
	task wr(input [3:0] a, input [31:0] v);
		integer i;
		reg ga, gw;
		begin
			@(posedge aclk);
			awaddr <= a;
			wdata <= v;
			awvalid <= 1'b1;
			wvalid <= 1'b1;
			bready <= 1'b1;
			for (i = 0; i < 40; i = i + 1) begin
				@(negedge aclk);
				ga = awvalid && awready;
				gw = wvalid && wready;
				if (bvalid) break;
				@(posedge aclk);
				if (ga) awvalid <= 1'b0;
				if (gw) wvalid <= 1'b0;
			end
			if (i == 40) tmo;
			chk("bresp", `RESP_OKAY, bresp);
			@(posedge aclk);
			bready <= 1'b0;
		end
	endtask
	task rd(input [3:0] a);
		integer i;
		reg g;
		begin
			@(posedge aclk);
			araddr <= a;
			arvalid <= 1'b1;
			rready <= 1'b1;
			for (i = 0; i < 40; i = i + 1) begin
				@(negedge aclk);
				g = arvalid && arready;
				if (rvalid) break;
				@(posedge aclk);
				if (g) arvalid <= 1'b0;
			end
			if (i == 40) tmo;
			d = rdata;
			r = rresp;
			@(posedge aclk);
			rready <= 1'b0;
		end
	endtask
	task wait_osc(input v);
		integer i;
		begin
			for (i = 0; i < 300 && osc !== v; i = i + 1) @(negedge aclk);
			if (i == 300) tmo;
		end
	endtask
	// toggles of each comp leg, and any high level on disabled outputs
	task tog;
		integer i;
		reg p0, p1, pv;
		begin
			n0 = 0;
			n1 = 0;
			nv = 0;
			hi = 1'b0;
			p0 = cmp[0];
			p1 = cmp[1];
			pv = vn;
			for (i = 0; i < 24; i = i + 1) begin
				@(negedge aclk);
				n0 = n0 + (cmp[0] !== p0);
				n1 = n1 + (cmp[1] !== p1);
				nv = nv + (vn !== pv);
				p0 = cmp[0];
				p1 = cmp[1];
				pv = vn;
				hi = hi | tru[1] | cmp[1] | vs;
			end
		end
	endtask
	function [4:0] spr_exp(input [3:0] code);
		case (code)
			4'h2: spr_exp = 5'h02;
			4'h3: spr_exp = 5'h04;
			4'h4: spr_exp = 5'h06;
			4'h5: spr_exp = 5'h08;
			4'h6: spr_exp = 5'h03;
			4'h7: spr_exp = 5'h05;
			4'h8: spr_exp = 5'h07;
			4'h9: spr_exp = 5'h12;
			4'hA: spr_exp = 5'h13;
			default: spr_exp = 5'h00;
		endcase
	endfunction
	initial begin
		n_fail = 0;
		num_checks = 0;
		{aresetn, pg_req, pd_req, stop_req, awvalid, wvalid, bready, arvalid, rready} = 9'h000;
		{awaddr, araddr, wdata} = 40'h00_0000_0000;
		strap = 1'b0;
		repeat (2) @(posedge aclk);
		aresetn <= 1'b1;
		pg_req <= 1'b1;
		wait_osc(1'b1);
		rd(`ADDR_CONTROL);
		chk("control", `CTL_RESET, d);
		rd(4'h8);
		chk("unmapped resp", `RESP_SLVERR, r);
		chk("unmapped data", 32'h0, d);
		for (c = 0; c < 16; c = c + 1) begin
			wr(`ADDR_CONTROL, 32'h0000_03F0 | c);
			repeat (4) @(posedge aclk);
			chk("spread", spr_exp(c), {center, pct});
			tog;
			chk("video run", spr_exp(c) != 5'h00, nv > 0);
		end
		wr(`ADDR_CONTROL, 32'h0000_03D2);
		@(posedge aclk) stop_req <= 1'b1;
		repeat (40) @(posedge aclk);
		tog;
		chk("parked pair", 32'h2, {tru[0], cmp[0]});
		chk("stopped toggles", 32'h0, n0);
		chk("running pair", 32'h1, n1 > 0);
		rd(`ADDR_STATUS);
		chk("status", 32'h0000_2292, d);
		@(posedge aclk) stop_req <= 1'b0;
		repeat (14) @(posedge aclk);
		tog;
		chk("restart", 32'h1, n0 > 4);
		wr(`ADDR_CONTROL, 32'h0000_0172);
		repeat (12) @(posedge aclk);
		tog;
		chk("disabled low", 32'h0, hi);
		wr(`ADDR_CONTROL, `CTL_RESET);
		@(posedge aclk) pd_req <= 1'b1;
		wait_osc(1'b0);
		chk("pd outputs", 32'h0, {tru, cmp, vn, vs});
		chk("pd video oe", 32'h3, {vn_oe, vs_oe});
		@(posedge aclk) pd_req <= 1'b0;
		wait_osc(1'b1);
		@(negedge aclk);
		chk("wake legs", 32'hC, {tru, cmp});
		repeat (40) @(posedge aclk);
		tog;
		chk("power up", 32'h1, n0 > 4 && n1 > 4);
		chk("video up", 32'h1, nv > 2);
		// second reset: strap set, power down asked for right after power good
		@(posedge aclk);
		aresetn <= 1'b0;
		pg_req <= 1'b0;
		strap <= 1'b1;
		repeat (2) @(posedge aclk);
		aresetn <= 1'b1;
		pg_req <= 1'b1;
		wait_osc(1'b1);
		@(posedge aclk) pd_req <= 1'b1;
		wait_osc(1'b0);
		@(negedge aclk);
		chk("early pd outputs", 32'h0, {tru, cmp});
		chk("strap video oe", 32'h0, {vn_oe, vs_oe});
		complete_run;
	end
endmodule

// ===== tb/platform_pin_model.sv
`timescale 1ns/10ps
// chipset side of the stop and power pins; requests come from the bench
module platform_pin_model (
	input  wire aclk,
	input  wire pg_req,
	input  wire pd_req,
	input  wire stop_req,
	output reg  power_good_down_n,
	output reg  cpu_stop_n
);
	initial begin
		power_good_down_n = 1'b0;
		cpu_stop_n = 1'b1;
	end
	// a power-down request may follow power good at once, well inside the initial window
	always @(posedge aclk) begin
		power_good_down_n <= pg_req && !pd_req;
		cpu_stop_n <= !stop_req;
	end
endmodule
